// [logic/rx_power_config_adc_regs.sv]
// Register bank for fault suppression, coil quality reference, contract power and converter.
// Assumes a converter front end that answers each start with one done pulse and a result.
// Fault inputs and the converter handshake share the register clock, so none is synchronised.
// Contract
// RL1 - Bit 0 of the protection register suppresses the cold fault when one and resets to one.
// RL2 - Faults start suppressed and suppression lifts after never, 5 s, 10 s or 20 s per a two-bit field.
// RL3 - The quality reference is an eight-bit read-write register at 41h that resets to 14h.
// RL4 - Offset 42h reads the six-bit contract power in half watts with bits 7 and 6 as zero.
// RL5 - The four-bit selector at 5Ch picks one of the seven converter channels.
// RL6 - The result of the selected channel is placed into the registers at 5Dh and 5Eh.
// RL7 - Offset 5Dh holds result bits 11 to 8 in bits 3 to 0, upper bits zero, read-only.
// RL8 - Offset 5Eh holds result bits 7 to 0, forming a 12-bit value with 5Dh.
// RL9 - A selector change reconverts the new channel before the result is reported valid.
`timescale 1ns/10ps
`default_nettype none
module rx_power_config_adc_regs
	import rx_regs_pkg::*;
#(
	parameter int RELEASE_5S_CYCLES = RELEASE_CYCLES_01,
	parameter int RELEASE_10S_CYCLES = RELEASE_CYCLES_10,
	parameter int RELEASE_20S_CYCLES = RELEASE_CYCLES_11
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [5:0] contract_power_level_i,
	input wire logic [6:0] fault_i,
	output logic [6:0] fault_o,
	output logic conv_start_o,
	output logic [3:0] conv_channel_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	output logic result_valid_o,
	output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////

	// Software visible state.
	logic [7:0] protection_reg;
	logic [7:0] quality_reg;
	logic [3:0] channel_reg;
	logic [11:0] result_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic [7:0] rdata_reg;

	// Release timer and gated faults.
	logic released_reg;
	logic [31:0] release_count_reg;
	logic [6:0] fault_reg;

	// Conversion sequencer.
	logic start_reg;
	logic pending_reg;
	conv_state_e state_reg;
	conv_state_e state_next;

	wire wr_protection = wr_i && (addr_i == ADDR_PROTECTION);
	wire wr_quality = wr_i && (addr_i == ADDR_QUALITY);
	wire wr_channel = wr_i && (addr_i == ADDR_CHANNEL);
	wire wr_irq_status = wr_i && (addr_i == ADDR_IRQ_STATUS);
	wire wr_irq_mask = wr_i && (addr_i == ADDR_IRQ_MASK);

	wire [3:0] channel_wdata = wdata_i[3:0];
	wire [1:0] mask_wdata = wdata_i[1:0];
	wire channel_change = wr_channel && (channel_wdata != channel_reg);
	wire [1:0] release_sel = protection_reg[RELEASE_LSB +: 2];

////////////////////////////////////////////////////////////////////////////////
// Release timer. The count clears whenever software changes the delay field and runs again only before release.

	// A 32-bit limit holds the longest delay at this clock with room to spare.
	wire release_never = (release_sel == 2'b00);
	wire release_short = (release_sel == 2'b01);
	wire release_medium = (release_sel == 2'b10);

	wire [31:0] release_limit =
		release_short ? 32'(RELEASE_5S_CYCLES) :
		release_medium ? 32'(RELEASE_10S_CYCLES) :
		32'(RELEASE_20S_CYCLES);
	wire release_hit = !release_never && !released_reg &&
		(release_count_reg >= release_limit - 32'h0000_0001);
	wire count_run = !released_reg && !release_never;
	wire release_field_write = wr_protection &&
		(wdata_i[RELEASE_LSB +: 2] != release_sel);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i || release_field_write) begin
			release_count_reg <= 32'h0000_0000;
		end else if (count_run) begin
			release_count_reg <= release_count_reg + 32'h0000_0001; // RL2
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			released_reg <= 1'b0;
		end else if (release_hit) begin
			released_reg <= 1'b1; // RL2
		end
	end

	// Each mask bit passes its fault only once released; bit 0 is the cold fault.
	// Mask bits 7..6 and 3..0 cover faults 6..5 and 3..0; fault 4 takes a constant one and is always masked.
	wire [6:0] mask_bits = {protection_reg[7:6], 1'b1, protection_reg[3:0]};
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_fault
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					fault_reg[gi] <= 1'b0;
				end else begin
					fault_reg[gi] <= fault_i[gi] && released_reg && !mask_bits[gi]; // RL1 RL2
				end
			end
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// Software registers. Each register has its own short process, so a decode slip
// touches only one of them.

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			protection_reg <= RESET_PROTECTION; // RL1
		end else if (wr_protection) begin
			protection_reg <= wdata_i; // RL1
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			quality_reg <= RESET_QUALITY; // RL3
		end else if (wr_quality) begin
			quality_reg <= wdata_i; // RL3
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			channel_reg <= RESET_CHANNEL;
		end else if (wr_channel) begin
			channel_reg <= channel_wdata; // RL5
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_mask_reg <= 2'h0;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= mask_wdata;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Conversion sequencer. A selector write that changes the channel during a conversion is remembered
// so the stale result is never flagged valid.

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = ST_CONVERT;
			ST_CONVERT: begin
				if (conv_done_i) begin
					state_next = (pending_reg || channel_change) ? ST_IDLE : ST_VALID;
				end
			end
			ST_VALID: begin
				if (channel_change) begin
					state_next = ST_IDLE; // RL9
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// The converter must answer every start; a lost done pulse stalls the sequencer.
	wire in_idle = (state_reg == ST_IDLE);
	wire capture = (state_reg == ST_CONVERT) && conv_done_i;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			start_reg <= in_idle;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pending_reg <= 1'b0;
		end else if (in_idle) begin
			pending_reg <= 1'b0;
		end else if (channel_change) begin
			pending_reg <= 1'b1; // RL9
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			result_reg <= 12'h000;
		end else if (capture) begin
			result_reg <= conv_data_i; // RL6
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status: bit 0 release reached, bit 1 fresh valid result.

	wire event_released = release_hit;
	wire event_result = (state_reg != ST_VALID) && (state_next == ST_VALID);
	wire [1:0] irq_events = {event_result, event_released};

	// Set wins over a clear in the same cycle, so no event is lost.
	genvar si;
	generate
		for (si = 0; si < 2; si++) begin : g_status
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					irq_status_reg[si] <= 1'b0;
				end else if (irq_events[si]) begin
					irq_status_reg[si] <= 1'b1;
				end else if (wr_irq_status && wdata_i[si]) begin
					irq_status_reg[si] <= 1'b0;
				end
			end
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read decode. Unmapped offsets read as zero.

	wire sel_protection = (addr_i == ADDR_PROTECTION);
	wire sel_quality = (addr_i == ADDR_QUALITY);
	wire sel_power = (addr_i == ADDR_POWER);
	wire sel_channel = (addr_i == ADDR_CHANNEL);
	wire sel_result_high = (addr_i == ADDR_RESULT_HIGH);
	wire sel_result_low = (addr_i == ADDR_RESULT_LOW);
	wire sel_irq_status = (addr_i == ADDR_IRQ_STATUS);
	wire sel_irq_mask = (addr_i == ADDR_IRQ_MASK);

	wire [7:0] rd_mux =
		sel_protection ? protection_reg :
		sel_quality ? quality_reg :
		sel_power ? {2'b00, contract_power_level_i} : // RL4
		sel_channel ? {4'h0, channel_reg} :
		sel_result_high ? {4'h0, result_reg[11:8]} : // RL7
		sel_result_low ? result_reg[7:0] : // RL8
		sel_irq_status ? {6'h00, irq_status_reg} :
		sel_irq_mask ? {6'h00, irq_mask_reg} : 8'h00;

	// Read data fall back to zero outside the answer cycle, so a late sample
	// cannot pick up a stale value.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rd_i ? rd_mux : 8'h00;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs. The interrupt lags the status by one cycle, which keeps
// the pin free of glitches.

	logic irq_reg;
	logic valid_reg;
	wire irq_pending = |(irq_status_reg & irq_mask_reg);
	wire valid_next = (state_next == ST_VALID);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_pending;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= valid_next; // RL9
		end
	end


	assign rdata_o = rdata_reg;
	assign fault_o = fault_reg;
	assign conv_start_o = start_reg;
	assign conv_channel_o = channel_reg;
	assign result_valid_o = valid_reg;
	assign irq_o = irq_reg;
endmodule
`default_nettype wire

// [logic/rx_regs_pkg.sv]
// Constants for the receiver configuration and converter register bank.
// Assumes byte-wide registers reached over a plain strobe port.
package rx_regs_pkg;
	localparam logic [7:0] ADDR_PROTECTION = 8'h2F;
	localparam logic [7:0] ADDR_QUALITY = 8'h41;
	localparam logic [7:0] ADDR_POWER = 8'h42;
	localparam logic [7:0] ADDR_CHANNEL = 8'h5C;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h5D;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h5E;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h70;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h71;
	localparam logic [7:0] RESET_PROTECTION = 8'hCF;
	localparam logic [7:0] RESET_QUALITY = 8'h14;
	localparam logic [3:0] RESET_CHANNEL = 4'h0;
	localparam int COLD_BIT = 0;
	localparam int RELEASE_LSB = 4;
	localparam int PROTECTION_WIDTH = 8;
	localparam int LAST_CHANNEL = 6;
	localparam int IRQ_RELEASED = 0;
	localparam int IRQ_RESULT = 1;
	localparam int CLK_HZ = 20_000_000;
	localparam int RELEASE_S_01 = 5;
	localparam int RELEASE_S_10 = 10;
	localparam int RELEASE_S_11 = 20;
	localparam int RELEASE_CYCLES_01 = RELEASE_S_01 * CLK_HZ;
	localparam int RELEASE_CYCLES_10 = RELEASE_S_10 * CLK_HZ;
	localparam int RELEASE_CYCLES_11 = RELEASE_S_11 * CLK_HZ;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONVERT = 3'b010,
		ST_VALID = 3'b100
	} conv_state_e;
endpackage

// [testbench/conv_model.sv]
// Converter front end model.
// Assumes one clock shared with the register bank.
`timescale 1ns/10ps
`default_nettype none
module conv_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [3:0] channel_i,
	output logic done_o,
	output logic [11:0] data_o
);
	logic [3:0] ch_reg;
	logic [2:0] wait_reg;
	// Data toggles outside the done pulse, so a late capture is caught.
	always_ff @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (reset_i) begin
			wait_reg <= 3'd0;
			data_o <= 12'h000;
		end else if (start_i) begin
			ch_reg <= channel_i;
			wait_reg <= 3'd4;
		end else if (wait_reg != 3'd0) begin
			wait_reg <= wait_reg - 3'd1;
			done_o <= (wait_reg == 3'd1);
			data_o <= (wait_reg == 3'd1) ? {ch_reg, 8'h5A ^ {4'h0, ch_reg}} : ~data_o;
		end
	end
endmodule
`default_nettype wire

// [testbench/rx_regs_chk.sv]
// Port checker for the register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module rx_regs_chk
	import rx_regs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [5:0] contract_power_level_i,
	input wire logic [6:0] fault_i,
	input wire logic [6:0] fault_o,
	input wire logic conv_start_o,
	input wire logic [3:0] conv_channel_o,
	input wire logic conv_done_i,
	input wire logic result_valid_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence reselect_seq;
		!result_valid_o ##[0:8] conv_start_o;
	endsequence
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata");
	a_power_read: assert property (rd_i && addr_i == ADDR_POWER |=>
		rdata_o == {2'b00, $past(contract_power_level_i)}) else $error("power");
	a_high_reserved: assert property (rd_i && addr_i == ADDR_RESULT_HIGH |=>
		rdata_o[7:4] == 4'h0) else $error("high");
	a_channel_write: assert property (wr_i && addr_i == ADDR_CHANNEL |=>
		conv_channel_o == $past(wdata_i[3:0])) else $error("channel");
	a_reselect_conv: assert property (wr_i && addr_i == ADDR_CHANNEL
		&& wdata_i[3:0] != conv_channel_o |=> reselect_seq) else $error("reselect");
	a_valid_cause: assert property ($rose(result_valid_o) |-> $past(conv_done_i)) else $error("valid");
	a_fault_cause: assert property ((fault_o & ~$past(fault_i)) == 7'h00) else $error("fault");
	a_start_reset: assert property ($fell(reset_i) |-> ##[0:3] conv_start_o) else $error("start");
endmodule
bind rx_power_config_adc_regs rx_regs_chk chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.contract_power_level_i(contract_power_level_i), .fault_i(fault_i), .fault_o(fault_o),
	.conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_done_i(conv_done_i),
	.result_valid_o(result_valid_o));
`default_nettype wire

// [testbench/rx_power_config_adc_regs_tb_top.sv]
// Self-checking bench for the register bank.
// Assumes the converter model answers every start.
`timescale 1ns/10ps
`default_nettype none
module rx_power_config_adc_regs_tb_top;
	import rx_regs_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done, valid, irq, start;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic [5:0] power = 6'h00;
	logic [6:0] fault_i = 7'h00, fault_o;
	logic [3:0] chan;
	logic [11:0] cdata;
	int failures = 0, checks_done = 0;
	initial forever #25 clk = ~clk;
	rx_power_config_adc_regs #(.RELEASE_5S_CYCLES(50), .RELEASE_10S_CYCLES(100),
		.RELEASE_20S_CYCLES(200)) dut (.clk_sys_i(clk), .reset_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .contract_power_level_i(power),
		.fault_i(fault_i), .fault_o(fault_o), .conv_start_o(start), .conv_channel_o(chan),
		.conv_done_i(done), .conv_data_i(cdata), .result_valid_o(valid), .irq_o(irq));
	conv_model model (.clk_sys_i(clk), .reset_i(rst), .start_i(start), .channel_i(chan),
		.done_o(done), .data_o(cdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check($sformatf("reg %h", a), v, exp);
	endtask
	task automatic wait_valid;
		int n;
		for (n = 0; n < 40 && valid !== 1'b1; n++) cyc(1);
		check("valid", {7'h0, valid}, 8'h01);
		if (valid !== 1'b1) begin
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdchk(ADDR_PROTECTION, 8'hCF);
		rdchk(ADDR_QUALITY, 8'h14);
		rdchk(ADDR_CHANNEL, 8'h00);
		rdchk(8'h00, 8'h00);
		bus(1'b1, ADDR_QUALITY, 8'hA5);
		rdchk(ADDR_QUALITY, 8'hA5);
		power <= 6'h3F;
		bus(1'b1, ADDR_POWER, 8'h00);
		rdchk(ADDR_POWER, 8'h3F);
		$display("registers done");
	endtask
	task automatic t_conv;
		for (int c = 0; c <= LAST_CHANNEL; c++) begin
			bus(1'b1, ADDR_CHANNEL, 8'((c + 1) % 7));
			bus(1'b1, ADDR_CHANNEL, 8'(c));
			wait_valid();
			bus(1'b1, ADDR_RESULT_HIGH, 8'hFF);
			rdchk(ADDR_RESULT_HIGH, 8'(c));
			rdchk(ADDR_RESULT_LOW, 8'h5A ^ 8'(c));
		end
		$display("converter done");
	endtask
	task automatic t_irq;
		bus(1'b1, ADDR_IRQ_MASK, 8'h02);
		bus(1'b1, ADDR_IRQ_STATUS, 8'h03);
		cyc(2);
		check("irq clear", {7'h0, irq}, 8'h00);
		bus(1'b1, ADDR_CHANNEL, 8'h05);
		wait_valid();
		cyc(3);
		check("irq set", {7'h0, irq}, 8'h01);
		bus(1'b1, ADDR_IRQ_MASK, 8'h00);
		cyc(2);
		check("irq masked", {7'h0, irq}, 8'h00);
		$display("interrupt done");
	endtask
	task automatic t_fault;
		fault_i <= 7'h01;
		bus(1'b1, ADDR_PROTECTION, 8'h90);
		cyc(40);
		check("held", {1'b0, fault_o}, 8'h00);
		cyc(20);
		check("released", {1'b0, fault_o}, 8'h01);
		rdchk(ADDR_IRQ_STATUS, 8'h03);
		bus(1'b1, ADDR_IRQ_STATUS, 8'h01);
		rdchk(ADDR_IRQ_STATUS, 8'h02);
		bus(1'b1, ADDR_PROTECTION, 8'h91);
		cyc(3);
		check("suppressed", {1'b0, fault_o}, 8'h00);
		$display("fault done");
	endtask
	initial begin
		cyc(4);
		rst <= 1'b0;
		t_regs();
		t_conv();
		t_irq();
		t_fault();
		final_report();
	end
	initial begin
		cyc(5000);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
